/* tb/test_watchdog_timer_with_lock.sv */
`timescale 1ns/1ns
module test_watchdog_timer_with_lock;
  logic       clock_i = 1'b0;
  logic       sys_rst_i = 1'b1;
  logic       xtal_i = 1'b0;
  logic       sfr_wr_i, sfr_rd_i, instr_end_i;
  logic [7:0] sfr_addr_i, sfr_wdata_i, sfr_rdata_o, default_key_o;
  logic [7:0] lock_key_byte_i = 8'hff;
  logic       prot_req_i = 1'b0;
  logic [7:0] prot_key_i = 8'hff;
  logic       sys_reset_o, download_reset_o, dog_irq_o, irq_high_prio_o;
  logic       prot_write_o, prot_deny_o;
  logic [7:0] rd;
  int         mismatches = 0;
  int         check_count = 0;
  int         cycles = 0;
  int         n;

  wdtl_watchdog wdtl_watchdog_i (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .xtal_i(xtal_i),
    .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i), .sfr_addr_i(sfr_addr_i),
    .sfr_wdata_i(sfr_wdata_i), .instr_end_i(instr_end_i), .lock_key_byte_i(lock_key_byte_i),
    .prot_req_i(prot_req_i), .prot_key_i(prot_key_i), .sfr_rdata_o(sfr_rdata_o),
    .sys_reset_o(sys_reset_o), .download_reset_o(download_reset_o), .dog_irq_o(dog_irq_o),
    .irq_high_prio_o(irq_high_prio_o), .default_key_o(default_key_o),
    .prot_write_o(prot_write_o), .prot_deny_o(prot_deny_o));
  wdtl_cpu_model wdtl_cpu_model_i (.clock_i(clock_i), .sfr_wr_o(sfr_wr_i), .sfr_rd_o(sfr_rd_i),
    .sfr_addr_o(sfr_addr_i), .sfr_wdata_o(sfr_wdata_i), .instr_end_o(instr_end_i),
    .sfr_rdata_i(sfr_rdata_o));

  // 25 mhz system clock
  always #20 clock_i = ~clock_i;

  // fast crystal stand-in (8 clocks a period) and the hang limit
  always @(posedge clock_i) begin
    cycles <= cycles + 1;
    if (cycles % 4 == 3) xtal_i <= ~xtal_i;
    if (cycles == 40000) begin
      mismatches++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    if (mismatches == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : chk

  // pin reset held for 8 cycles
  task automatic rst();
    @(posedge clock_i);
    sys_rst_i <= 1'b1;
    repeat (8) @(posedge clock_i);
    sys_rst_i <= 1'b0;
  endtask : rst

  // bounded wait: 0 interrupt, 1 system reset; n counts the cycles taken
  task automatic wait_hi(input int k);
    #1 n = 0;
    while ((k == 0 ? dog_irq_o : sys_reset_o) !== 1'b1 && n < 6000) begin
      @(posedge clock_i);
      #1 n++;
    end
  endtask : wait_hi

  // protection request with one key; answer is {write, deny}
  task automatic prot(input logic [7:0] k, input logic [7:0] exp);
    @(posedge clock_i);
    prot_key_i <= k;
    prot_req_i <= 1'b1;
    @(posedge clock_i);
    prot_req_i <= 1'b0;
    #1 chk({6'h00, prot_write_o, prot_deny_o}, exp);
  endtask : prot

  initial begin
    rst();
    wdtl_cpu_model_i.read_ctl(rd);
    chk(rd, 8'h72);
    chk({7'h00, irq_high_prio_o}, 8'h01);
    chk(default_key_o, 8'hff);
    // foreign address does not arm, write without unlock, unlock lost to two instructions
    wdtl_cpu_model_i.access(1'b1, 8'hc8, 8'h01);
    wdtl_cpu_model_i.access(1'b1, 8'hc0, 8'h30);
    wdtl_cpu_model_i.read_ctl(rd);
    chk(rd, 8'h72);
    wdtl_cpu_model_i.access(1'b1, 8'hc0, 8'h01);
    wdtl_cpu_model_i.other_instr();
    wdtl_cpu_model_i.other_instr();
    wdtl_cpu_model_i.access(1'b1, 8'hc0, 8'h30);
    wdtl_cpu_model_i.read_ctl(rd);
    chk(rd, 8'h72);
    // shortest timeout in interrupt mode: 512 crystal periods
    wdtl_cpu_model_i.write_ctl(8'h0a);
    wdtl_cpu_model_i.read_ctl(rd);
    chk(rd, 8'h0a);
    wait_hi(0);
    chk({7'h00, n >= 4070 && n <= 4120}, 8'h01);
    wdtl_cpu_model_i.read_ctl(rd);
    chk(rd, 8'h0e);
    chk({6'h00, dog_irq_o, sys_reset_o}, 8'h02);
    // flag cleared by writing zero, then kicks keep the dog quiet
    wdtl_cpu_model_i.write_ctl(8'h0a);
    wdtl_cpu_model_i.read_ctl(rd);
    chk({rd[7:1], dog_irq_o}, 8'h0a);
    repeat (2) begin
      repeat (3000) @(posedge clock_i);
      wdtl_cpu_model_i.write_ctl(8'h0a);
    end
    chk({7'h00, dog_irq_o}, 8'h00);
    // reset mode: expiry resets, flag survives, settings return
    wdtl_cpu_model_i.write_ctl(8'h02);
    wait_hi(1);
    chk({7'h00, sys_reset_o}, 8'h01);
    repeat (8) @(posedge clock_i);
    wdtl_cpu_model_i.read_ctl(rd);
    chk(rd, 8'h76);
    // immediate reset codes
    for (int c = 8; c < 10; c++) begin
      wdtl_cpu_model_i.write_ctl({c[3:0], 4'h2});
      wait_hi(1);
      chk({6'h00, n < 3, download_reset_o}, {6'h00, 1'b1, c == 9});
      repeat (8) @(posedge clock_i);
    end
    rst();
    wdtl_cpu_model_i.read_ctl(rd);
    chk(rd, 8'h72);
    // flash lock applied
    @(posedge clock_i);
    lock_key_byte_i <= 8'h7f;
    repeat (3) @(posedge clock_i);
    chk(default_key_o, 8'h7f);
    wdtl_cpu_model_i.write_ctl(8'h38);
    wdtl_cpu_model_i.read_ctl(rd);
    chk(rd, 8'h32);
    prot(8'h7f, 8'h02);
    prot(8'hff, 8'h01);
    print_verdict();
  end
endmodule : test_watchdog_timer_with_lock

/* tb/wdtl_cpu_model.sv */
`timescale 1ns/1ns
// cpu side of the special-function bus, one access per call, two for write_ctl and none for other_instr
module wdtl_cpu_model (
  input  wire logic       clock_i,
  output logic            sfr_wr_o,
  output logic            sfr_rd_o,
  output logic      [7:0] sfr_addr_o,
  output logic      [7:0] sfr_wdata_o,
  output logic            instr_end_o,
  input  wire logic [7:0] sfr_rdata_i
);
  // bus idle from time zero
  initial begin
    sfr_wr_o    = 1'b0;
    sfr_rd_o    = 1'b0;
    sfr_addr_o  = 8'hc0;
    sfr_wdata_o = 8'h00;
    instr_end_o = 1'b0;
  end

  // one-cycle strobe, address and data held through the sampling edge
  task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_i);
    sfr_wr_o    <= wr;
    sfr_rd_o    <= ~wr;
    sfr_addr_o  <= a;
    sfr_wdata_o <= d;
    @(posedge clock_i);
    sfr_wr_o <= 1'b0;
    sfr_rd_o <= 1'b0;
  endtask : access

  // unlock then the protected write right behind it; its unlock bit is forced to zero, selector passed as given
  task automatic write_ctl(input logic [7:0] d);
    access(1'b1, 8'hc0, 8'h01);
    access(1'b1, 8'hc0, {d[7:1], 1'b0});
  endtask : write_ctl

  // read data stands for the cycle after the strobe
  task automatic read_ctl(output logic [7:0] d);
    access(1'b0, 8'hc0, 8'h00);
    #1 d = sfr_rdata_i;
  endtask : read_ctl

  // end of some unrelated instruction
  task automatic other_instr();
    @(posedge clock_i);
    instr_end_o <= 1'b1;
    @(posedge clock_i);
    instr_end_o <= 1'b0;
  endtask : other_instr
endmodule : wdtl_cpu_model

/* verilog/wdtl_pkg.sv */
package wdtl_pkg;

  // control register placement in the special-function space
  localparam logic [7:0]  DOG_CONTROL_ADDR   = 8'hc0;
  // flash location of the lock and key byte, and the protected range
  localparam logic [15:0] LOCK_KEY_ADDR      = 16'h3ffa;
  localparam logic [15:0] PROT_FIRST_ADDR    = 16'h3ffb;
  localparam logic [15:0] PROT_LAST_ADDR     = 16'h3fff;

  // field positions inside dog_control
  localparam int unsigned SEL_LSB            = 4;
  localparam int unsigned RESP_BIT           = 3;
  localparam int unsigned FLAG_BIT           = 2;
  localparam int unsigned ENABLE_BIT         = 1;
  localparam int unsigned UNLOCK_BIT         = 0;
  // position of the lock bit in the flash byte
  localparam int unsigned LOCK_BIT           = 7;

  // reset values
  localparam logic [3:0]  SEL_RST            = 4'h7;
  localparam logic        RESP_RST           = 1'b0;
  localparam logic        FLAG_RST           = 1'b0;
  localparam logic        ENABLE_RST         = 1'b1;
  localparam logic [7:0]  LOCK_KEY_RST       = 8'hff;

  // selector codes
  localparam logic [3:0]  SEL_LONGEST        = 4'h7;
  localparam logic [3:0]  SEL_IMM_RESET      = 4'h8;
  localparam logic [3:0]  SEL_DOWNLOAD       = 4'h9;
  // timeout is 2^sel times 2^9 crystal periods
  localparam logic [4:0]  TAP_BASE           = 5'h09;

  // flash key seen when the watchdog lock is applied or not
  localparam logic [7:0]  KEY_LOCKED         = 8'h7f;
  localparam logic [7:0]  KEY_UNLOCKED       = 8'hff;

  // timing: system and crystal clocks and reset pulse length
  localparam int unsigned CLK_HZ             = 25000000;
  localparam int unsigned XTAL_HZ            = 32768;
  localparam int unsigned RST_PULSE_NS       = 200;
  localparam int unsigned RST_PULSE_CYC      = (RST_PULSE_NS * (CLK_HZ / 1000000) + 999) / 1000;

  typedef enum logic {WDTL_RG_IDLE, WDTL_RG_PULSE} wdtl_rg_e;

endpackage : wdtl_pkg

/* verilog/wdtl_watchdog.sv */
`timescale 1ns/1ns
module wdtl_watchdog #(
  parameter int unsigned CNT_W = 16
) (
  input  wire logic       clock_i,
  input  wire logic       sys_rst_i,
  input  wire logic       xtal_i,
  input  wire logic       sfr_wr_i,
  input  wire logic       sfr_rd_i,
  input  wire logic [7:0] sfr_addr_i,
  input  wire logic [7:0] sfr_wdata_i,
  input  wire logic       instr_end_i,
  input  wire logic [7:0] lock_key_byte_i,
  input  wire logic       prot_req_i,
  input  wire logic [7:0] prot_key_i,
  output logic      [7:0] sfr_rdata_o,
  output logic            sys_reset_o,
  output logic            download_reset_o,
  output logic            dog_irq_o,
  output logic            irq_high_prio_o,
  output logic      [7:0] default_key_o,
  output logic            prot_write_o,
  output logic            prot_deny_o
);

  logic             xtal_s1_reg;
  logic             xtal_s2_reg;
  logic             xtal_s3_reg;
  logic             tick;
  logic [7:0]       key_byte_reg;
  logic             lock;
  logic [3:0]       sel_reg;
  logic             resp_reg;
  logic             flag_reg;
  logic             en_reg;
  logic             armed_reg;
  logic             seen_end_reg;
  logic             en_eff;
  logic             resp_eff;
  logic             ctl_wr;
  logic             arm_wr;
  logic             acc_wr;
  logic [3:0]       wr_sel;
  logic             kick;
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W:0]   span;
  logic [CNT_W-1:0] term;
  logic             hit;
  logic             to_event;
  logic             imm_event;
  logic             trigger;
  wdtl_pkg::wdtl_rg_e rg_reg;
  logic [2:0]       rg_cnt_reg;

  // crystal clock is foreign: two flops, then a third for the edge
  always_ff @(posedge clock_i) begin
    xtal_s1_reg <= xtal_i;
    xtal_s2_reg <= xtal_s1_reg;
    xtal_s3_reg <= xtal_s2_reg;
  end
  assign tick = xtal_s2_reg & ~xtal_s3_reg; // one pulse per crystal period

  // flash byte is on this clock; its top bit is the lock, active low
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      key_byte_reg <= wdtl_pkg::LOCK_KEY_RST;
    end else begin
      key_byte_reg <= lock_key_byte_i;
    end
  end
  assign lock = ~key_byte_reg[wdtl_pkg::LOCK_BIT];

  // effective enable and response after the lock forcing
  assign en_eff   = lock | en_reg;
  assign resp_eff = ~lock & resp_reg;

  // write decode: unlock write, then the accepted write
  assign ctl_wr = sfr_wr_i && (sfr_addr_i == wdtl_pkg::DOG_CONTROL_ADDR);
  assign arm_wr = ctl_wr && !armed_reg && sfr_wdata_i[wdtl_pkg::UNLOCK_BIT];
  assign acc_wr = ctl_wr && armed_reg;
  assign wr_sel = sfr_wdata_i[wdtl_pkg::SEL_LSB +: 4];
  assign kick   = acc_wr && sfr_wdata_i[wdtl_pkg::ENABLE_BIT];

  // unlock window: open after the arming write, shut after one more instruction
  always_ff @(posedge clock_i) begin
    if (sys_rst_i || trigger) begin
      armed_reg    <= 1'b0;
      seen_end_reg <= 1'b0;
    end else if (arm_wr) begin
      armed_reg    <= 1'b1;
      seen_end_reg <= instr_end_i; // end of the arming instruction itself
    end else if (acc_wr) begin
      armed_reg    <= 1'b0;
      seen_end_reg <= 1'b0;
    end else if (armed_reg && instr_end_i) begin
      armed_reg    <= ~seen_end_reg;
      seen_end_reg <= 1'b1;
    end
  end

  // terminal count of the selected tap
  assign span = (CNT_W+1)'(1) << (5'(sel_reg) + wdtl_pkg::TAP_BASE);
  assign term = CNT_W'(span - (CNT_W+1)'(1));
  assign hit  = (sel_reg <= wdtl_pkg::SEL_LONGEST) && (cnt_reg == term);

  // expiry and immediate-reset events
  assign to_event  = tick && en_eff && hit && !kick && (rg_reg == wdtl_pkg::WDTL_RG_IDLE);
  assign imm_event = acc_wr && (rg_reg == wdtl_pkg::WDTL_RG_IDLE)
                     && ((wr_sel == wdtl_pkg::SEL_IMM_RESET)
                      || (wr_sel == wdtl_pkg::SEL_DOWNLOAD));
  assign trigger   = imm_event || (to_event && !resp_eff);

  // control fields; a watchdog reset restores them but not the flag
  always_ff @(posedge clock_i) begin
    if (sys_rst_i || trigger) begin
      sel_reg  <= wdtl_pkg::SEL_RST;
      resp_reg <= wdtl_pkg::RESP_RST;
      en_reg   <= wdtl_pkg::ENABLE_RST;
    end else if (acc_wr) begin
      sel_reg <= wr_sel;
      if (!lock) begin
        resp_reg <= sfr_wdata_i[wdtl_pkg::RESP_BIT];
        en_reg   <= sfr_wdata_i[wdtl_pkg::ENABLE_BIT];
      end
    end
  end

  // timeout flag: set wins over a clearing write; pin reset clears it, a watchdog reset does not
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      flag_reg <= wdtl_pkg::FLAG_RST;
    end else if (to_event || imm_event) begin
      flag_reg <= 1'b1;
    end else if (acc_wr && !sfr_wdata_i[wdtl_pkg::FLAG_BIT]) begin
      flag_reg <= 1'b0;
    end
  end

  // watchdog counter
  always_ff @(posedge clock_i) begin
    if (sys_rst_i || trigger || kick || !en_eff) begin
      cnt_reg <= '0;
    end else if (tick) begin
      cnt_reg <= hit ? '0 : cnt_reg + CNT_W'(1);
    end
  end

  // interrupt: pending until software clears the flag
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      dog_irq_o <= 1'b0;
    end else if (to_event && resp_eff) begin
      dog_irq_o <= 1'b1;
    end else if (acc_wr && !sfr_wdata_i[wdtl_pkg::FLAG_BIT]) begin
      dog_irq_o <= 1'b0;
    end
  end

  // priority is fixed high, outside the global enable
  always_ff @(posedge clock_i) begin
    irq_high_prio_o <= 1'b1;
  end

  // reset pulse generator
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      rg_reg           <= wdtl_pkg::WDTL_RG_IDLE;
      rg_cnt_reg       <= '0;
      sys_reset_o      <= 1'b0;
      download_reset_o <= 1'b0;
    end else if (rg_reg == wdtl_pkg::WDTL_RG_IDLE) begin
      if (trigger) begin
        rg_reg           <= wdtl_pkg::WDTL_RG_PULSE;
        rg_cnt_reg       <= 3'(wdtl_pkg::RST_PULSE_CYC - 1);
        sys_reset_o      <= 1'b1;
        download_reset_o <= imm_event && (wr_sel == wdtl_pkg::SEL_DOWNLOAD);
      end
    end else if (rg_cnt_reg == 3'h0) begin
      rg_reg           <= wdtl_pkg::WDTL_RG_IDLE;
      sys_reset_o      <= 1'b0;
      download_reset_o <= 1'b0;
    end else begin
      rg_cnt_reg <= rg_cnt_reg - 3'h1;
    end
  end

  // register read port
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      sfr_rdata_o <= 8'h00;
    end else if (sfr_rd_i && (sfr_addr_i == wdtl_pkg::DOG_CONTROL_ADDR)) begin
      sfr_rdata_o <= {sel_reg, resp_eff, flag_reg, en_eff, armed_reg};
    end else begin
      sfr_rdata_o <= 8'h00;
    end
  end

  // flash key: lock bit doubles as top key bit; compare before programming
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      default_key_o <= wdtl_pkg::KEY_UNLOCKED;
      prot_write_o  <= 1'b0;
      prot_deny_o   <= 1'b0;
    end else begin
      default_key_o <= lock ? wdtl_pkg::KEY_LOCKED : wdtl_pkg::KEY_UNLOCKED;
      prot_write_o  <= prot_req_i && (prot_key_i == key_byte_reg);
      prot_deny_o   <= prot_req_i && (prot_key_i != key_byte_reg);
    end
  end

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);

  // arming write with no instruction end in its own cycle
  sequence arm_s;
    arm_wr && !instr_end_i && !trigger;
  endsequence

  // second instruction end while the unlock window is still open
  sequence second_end_s;
    armed_reg && seen_end_reg && instr_end_i && !ctl_wr;
  endsequence

  // accepted write clearing the flag with no timeout racing it
  sequence flag_clear_s;
    acc_wr && !sfr_wdata_i[wdtl_pkg::FLAG_BIT] && !to_event && !imm_event;
  endsequence

  // read of the control register
  sequence ctl_read_s;
    sfr_rd_i && (sfr_addr_i == wdtl_pkg::DOG_CONTROL_ADDR);
  endsequence

  timeout_reset_a: assert property (to_event && !resp_eff |=> sys_reset_o && !dog_irq_o)
    else $error("expiry in reset mode gave no reset");
  timeout_irq_a: assert property (to_event && resp_eff |=> dog_irq_o && !sys_reset_o)
    else $error("expiry in interrupt mode gave no interrupt");
  flag_set_a: assert property (to_event |=> flag_reg)
    else $error("timeout flag not set");
  flag_keep_a: assert property (flag_reg && !acc_wr |=> flag_reg)
    else $error("timeout flag lost without a clearing write");
  imm_reset_a: assert property (imm_event && wr_sel == 4'h8 |=> sys_reset_o && !download_reset_o)
    else $error("code 1000 gave no plain reset");
  dl_reset_a: assert property (imm_event && wr_sel == 4'h9 |=> sys_reset_o && download_reset_o)
    else $error("code 1001 gave no download reset");
  pulse_len_a: assert property ($rose(sys_reset_o) |-> sys_reset_o[*5] ##1 !sys_reset_o)
    else $error("reset pulse length wrong");
  reset_dflt_a: assert property ($rose(sys_reset_o) |-> sel_reg == 4'h7 && en_reg)
    else $error("control not restored by watchdog reset");
  kick_clear_a: assert property (kick && !trigger |=> cnt_reg == '0)
    else $error("kick did not clear counter");
  count_up_a: assert property (tick && en_eff && !hit && !kick && !trigger
                               |=> cnt_reg == $past(cnt_reg) + CNT_W'(1))
    else $error("counter did not advance on crystal tick");
  no_unlock_a: assert property (ctl_wr && !armed_reg && !trigger |=> $stable(sel_reg))
    else $error("control changed without unlock");
  lock_hold_a: assert property (lock && acc_wr && !trigger |=> $stable(en_reg) && $stable(resp_reg))
    else $error("locked bits changed");
  lock_sel_a: assert property (lock && acc_wr && !trigger |=> sel_reg == $past(wr_sel))
    else $error("selector refused while locked");
  arm_open_a: assert property (arm_s |=> armed_reg && !seen_end_reg)
    else $error("unlock write did not open the window");
  relock_a: assert property (second_end_s |=> !armed_reg)
    else $error("unlock survived an intervening instruction");
  key_match_a: assert property (prot_req_i && prot_key_i == key_byte_reg |=> prot_write_o && !prot_deny_o)
    else $error("matching key did not allow protection write");
  key_msb_a: assert property (lock |=> default_key_o == 8'h7f || $past(lock) != lock)
    else $error("locked default key not 0x7f");

  // flag, read-back, lock, download pairing, protection, counter hold and priority checks
  imm_flag_a: assert property (imm_event |=> flag_reg)
    else $error("immediate reset did not set the timeout flag");
  flag_clear_a: assert property (flag_clear_s |=> !flag_reg && !dog_irq_o)
    else $error("clearing write left flag or interrupt set");
  read_flag_a: assert property (ctl_read_s
                                |=> sfr_rdata_o[wdtl_pkg::FLAG_BIT] == $past(flag_reg))
    else $error("read-back flag differs from flag");
  read_lock_a: assert property (sfr_rd_i && (sfr_addr_i == wdtl_pkg::DOG_CONTROL_ADDR) && lock
                                |=> sfr_rdata_o[wdtl_pkg::ENABLE_BIT]
                                 && !sfr_rdata_o[wdtl_pkg::RESP_BIT])
    else $error("locked read-back not forced");
  dl_pair_a: assert property (download_reset_o |-> sys_reset_o)
    else $error("download reset without system reset");
  prot_deny_a: assert property (prot_req_i && prot_key_i != key_byte_reg |=> prot_deny_o && !prot_write_o)
    else $error("wrong key not refused");
  count_hold_a: assert property (!tick && !kick && en_eff && !trigger |=> $stable(cnt_reg))
    else $error("counter moved without crystal tick");
  prio_const_a: assert property (irq_high_prio_o)
    else $error("watchdog interrupt not high priority");

endmodule : wdtl_watchdog
